// File: core/oamd_pkg.sv
// Package with mode codes, state codes, constants and decode helpers for the address decoder.
package oamd_pkg;

  // Operand addressing modes: seventeen codes in seven families.
  typedef enum logic [4:0] {
    OAMD_INH    = 5'h00, // Inherent, no operand bytes.
    OAMD_IMM    = 5'h01, // Immediate operand value.
    OAMD_SDIR   = 5'h02, // Short direct, page-zero address byte.
    OAMD_LDIR   = 5'h03, // Long direct, address word.
    OAMD_IX0    = 5'h04, // Indexed without offset.
    OAMD_IX1    = 5'h05, // Indexed with byte offset.
    OAMD_IX2    = 5'h06, // Indexed with word offset.
    OAMD_SIND   = 5'h07, // Short indirect, byte pointer.
    OAMD_LIND   = 5'h08, // Long indirect, word pointer.
    OAMD_SINDX  = 5'h09, // Short indirect indexed.
    OAMD_LINDX  = 5'h0a, // Long indirect indexed.
    OAMD_REL    = 5'h0b, // Relative, signed displacement byte.
    OAMD_RELIND = 5'h0c, // Relative indirect, displacement read via pointer.
    OAMD_BITDIR = 5'h0d, // Bit operation on a page-zero byte.
    OAMD_BITIND = 5'h0e, // Bit operation through a byte pointer.
    OAMD_BTJDIR = 5'h0f, // Bit test and jump, direct.
    OAMD_BTJIND = 5'h10  // Bit test and jump, through a byte pointer.
  } oamd_mode_type;

  // Controller states, one-hot.
  typedef enum logic [3:0] {
    CTL_IDLE = 4'h1, // Waiting for a start request.
    CTL_INST = 4'h2, // Reading the bytes that follow the opcode.
    CTL_PTR  = 4'h4, // Reading the page-zero pointer.
    CTL_CALC = 4'h8  // Forming the effective address.
  } oamd_state_type;

  // Reset values and fixed figures.
  localparam logic [7:0] OAMD_ZERO_PAGE = 8'h00; // High byte of every page-zero address.
  localparam logic [7:0] OAMD_BYTE_RST = 8'h00; // Reset value of captured bytes.
  localparam logic [15:0] OAMD_WORD_RST = 16'h0000; // Reset value of address words.
  localparam logic [15:0] OAMD_SHORT_IDX_MAX = 16'h01fe; // Top of the short indexed reach.
  localparam logic [1:0] OAMD_PHASE_ISSUE = 2'h0; // Phase that issues a read.
  localparam logic [1:0] OAMD_PHASE_DATA = 2'h2; // Phase in which read data is valid.
  localparam logic [1:0] OAMD_CNT_RST = 2'h0; // Reset value of byte counters.

  // Bytes read from the instruction stream after the opcode and any prefix.
  function automatic logic [1:0] oamd_inst_bytes(input oamd_mode_type m);
    unique case (m)
      OAMD_INH, OAMD_IX0: oamd_inst_bytes = 2'h0;
      OAMD_LDIR, OAMD_IX2, OAMD_BTJDIR, OAMD_BTJIND: oamd_inst_bytes = 2'h2;
      default: oamd_inst_bytes = 2'h1;
    endcase
  endfunction

  // Bytes read from the page-zero pointer.
  function automatic logic [1:0] oamd_ptr_bytes(input oamd_mode_type m);
    unique case (m)
      OAMD_LIND, OAMD_LINDX: oamd_ptr_bytes = 2'h2;
      OAMD_SIND, OAMD_SINDX, OAMD_RELIND, OAMD_BITIND, OAMD_BTJIND: oamd_ptr_bytes = 2'h1;
      default: oamd_ptr_bytes = 2'h0;
    endcase
  endfunction

  // Long forms, which reach the full 64 Kbyte space.
  function automatic logic oamd_is_long(input oamd_mode_type m);
    oamd_is_long = (m == OAMD_LDIR) || (m == OAMD_IX2) || (m == OAMD_LIND) || (m == OAMD_LINDX);
  endfunction

  // Instruction length beyond the opcode, prefix bytes included.
  function automatic logic [1:0] oamd_len(input oamd_mode_type m);
    unique case (m)
      OAMD_INH, OAMD_IX0: oamd_len = 2'h0;
      OAMD_IMM, OAMD_SDIR, OAMD_IX1, OAMD_REL, OAMD_BITDIR: oamd_len = 2'h1;
      OAMD_BTJIND: oamd_len = 2'h3;
      default: oamd_len = 2'h2;
    endcase
  endfunction

endpackage

// File: core/oamd_decoder.sv
// Operand addressing mode decoder: fetches operand bytes and forms the effective address.
// How it works
// RULE_01: Seventeen modes in seven families; others rejected.
// RULE_02: Immediate takes one byte as operand value.
// RULE_03: Short direct reads one page-zero address byte.
// RULE_04: Long direct reads a two-byte address word.
// RULE_05: Indexed address is unsigned index plus offset.
// RULE_06: No-offset indexed reads nothing, uses index alone.
// RULE_07: Byte-offset indexed sum reaches up to 1FE.
// RULE_08: Word-offset indexed reads two bytes, full space.
// RULE_09: Read-modify-write accepts short forms only.
// RULE_10: Long forms cost more bytes and cycles.
// RULE_11: Indirect reads page-zero pointer, then optional index.
`timescale 1ns/1ns
`default_nettype none

module oamd_decoder
  import oamd_pkg::*;
(
  input wire logic i_clk, // Core clock, 125 MHz.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_ce, // Clock enable; all state holds while low.
  input wire logic i_start, // Request to decode one operand, taken when idle.
  input wire logic [4:0] i_mode, // Addressing mode code of the request.
  input wire logic i_rmw, // High when the instruction is read-modify-write.
  input wire logic [7:0] i_index, // Selected index register value.
  input wire logic [15:0] i_pc, // Address of the first byte after the opcode.
  input wire logic [7:0] i_mem_data, // Memory read data, valid the cycle after a read.
  output logic o_busy, // High while a request is being worked.
  output logic o_done, // One-cycle pulse with the result.
  output logic o_err, // Request refused, valid with o_done.
  output logic [15:0] o_ea, // Effective operand address or branch target.
  output logic [7:0] o_operand, // Immediate value or branch displacement.
  output logic [1:0] o_len, // Instruction bytes beyond the opcode.
  output logic o_mem_rd, // Memory read strobe.
  output logic [15:0] o_mem_addr // Memory read address.
);

  oamd_state_type state_q; // Controller state.
  logic [1:0] phase_q; // Step within one memory read.
  logic [1:0] cnt_q; // Bytes read so far in the current state.
  logic err_q; // Request refused.
  oamd_mode_type mode_q; // Captured mode.
  logic rmw_q; // Captured read-modify-write flag.
  logic [7:0] idx_q; // Captured index register.
  logic [15:0] pc_q; // Captured instruction stream address.
  logic [7:0] inst_q [2]; // Bytes read after the opcode.
  logic [7:0] ptr_q [2]; // Pointer bytes read from page zero.
  logic busy_q; // Busy flag.
  logic done_q; // Result pulse.
  logic [15:0] ea_q; // Result address.
  logic [7:0] operand_q; // Result operand byte.
  logic [1:0] len_q; // Result length.
  logic mem_rd_q; // Read strobe.
  logic [15:0] mem_addr_q; // Read address.
  logic [15:0] ea_d; // Next result address.
  logic [7:0] operand_d; // Next result operand byte.
  logic [2:0] rd_cnt_q; // Reads issued for this request, watched by the checks.
  oamd_mode_type mode_in; // Incoming mode as a typed value.
  logic bad_in; // Incoming request must be refused.
  logic [1:0] step_bytes; // Bytes to read in the current reading state.

  // Incoming request decode.
  assign mode_in = oamd_mode_type'(i_mode);
  assign bad_in = (i_mode > OAMD_BTJIND) || (i_rmw && oamd_is_long(mode_in)); // RULE_01 RULE_09

  // Instruction and pointer reads share one sequence; only the byte count differs.
  assign step_bytes = (state_q == CTL_PTR) ? oamd_ptr_bytes(mode_q) : oamd_inst_bytes(mode_q);

  // Controller sequence; each memory read takes three steps: issue, wait, capture.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= CTL_IDLE;
      phase_q <= OAMD_PHASE_ISSUE;
      cnt_q <= OAMD_CNT_RST;
      err_q <= 1'b0;
    end
    else if (i_ce)
    begin
      unique case (state_q)
        CTL_IDLE:
        begin
          phase_q <= OAMD_PHASE_ISSUE;
          cnt_q <= OAMD_CNT_RST;
          if (i_start)
          begin
            err_q <= bad_in;
            // A refused request or one with no following byte goes straight to the result.
            if (bad_in || (oamd_inst_bytes(mode_in) == 2'h0))
            begin
              state_q <= CTL_CALC; // RULE_06
            end
            else
            begin
              state_q <= CTL_INST;
            end
          end
        end
        CTL_INST, CTL_PTR:
        begin
          if (phase_q == OAMD_PHASE_DATA)
          begin
            phase_q <= OAMD_PHASE_ISSUE;
            if ((cnt_q + 2'h1) != step_bytes)
            begin
              cnt_q <= cnt_q + 2'h1; // RULE_04 RULE_08 RULE_10 RULE_11
            end
            else
            begin
              // The last instruction byte moves on to the pointer, if any, or to the result.
              cnt_q <= OAMD_CNT_RST;
              if ((state_q == CTL_INST) && (oamd_ptr_bytes(mode_q) != 2'h0))
              begin
                state_q <= CTL_PTR; // RULE_11
              end
              else
              begin
                state_q <= CTL_CALC;
              end
            end
          end
          else
          begin
            phase_q <= phase_q + 2'h1;
          end
        end
        CTL_CALC:
        begin
          state_q <= CTL_IDLE;
        end
        default:
        begin
          // An illegal state code recovers to idle.
          state_q <= CTL_IDLE;
        end
      endcase
    end
  end

  // Request capture; held until the next request so results stay consistent.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      mode_q <= OAMD_INH;
      rmw_q <= 1'b0;
      idx_q <= OAMD_BYTE_RST;
      pc_q <= OAMD_WORD_RST;
    end
    else if (i_ce && (state_q == CTL_IDLE) && i_start)
    begin
      mode_q <= mode_in;
      rmw_q <= i_rmw;
      idx_q <= i_index;
      pc_q <= i_pc;
    end
  end

  // Byte capture from memory; words arrive high byte first.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      inst_q <= '{OAMD_BYTE_RST, OAMD_BYTE_RST};
      ptr_q <= '{OAMD_BYTE_RST, OAMD_BYTE_RST};
    end
    else if (i_ce)
    begin
      if ((state_q == CTL_IDLE) && i_start)
      begin
        // Clear stale bytes so unused ones read as zero.
        inst_q <= '{OAMD_BYTE_RST, OAMD_BYTE_RST};
        ptr_q <= '{OAMD_BYTE_RST, OAMD_BYTE_RST};
      end
      else if ((state_q == CTL_INST) && (phase_q == OAMD_PHASE_DATA))
      begin
        inst_q[cnt_q[0]] <= i_mem_data; // RULE_02 RULE_03
      end
      else if ((state_q == CTL_PTR) && (phase_q == OAMD_PHASE_DATA))
      begin
        ptr_q[cnt_q[0]] <= i_mem_data; // RULE_11
      end
    end
  end

  // Memory read strobe and address.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      mem_rd_q <= 1'b0;
      mem_addr_q <= OAMD_WORD_RST;
    end
    else if (i_ce)
    begin
      mem_rd_q <= 1'b0;
      if ((state_q == CTL_INST) && (phase_q == OAMD_PHASE_ISSUE))
      begin
        // Instruction bytes follow the opcode in order.
        mem_rd_q <= 1'b1;
        mem_addr_q <= pc_q + {15'h0000, cnt_q[0]};
      end
      else if ((state_q == CTL_PTR) && (phase_q == OAMD_PHASE_ISSUE))
      begin
        // Pointer bytes always sit in page zero and wrap within it.
        mem_rd_q <= 1'b1;
        mem_addr_q <= {OAMD_ZERO_PAGE, inst_q[0] + {7'h00, cnt_q[0]}}; // RULE_11
      end
    end
  end

  // Effective address and operand for each mode.
  always_comb
  begin
    ea_d = OAMD_WORD_RST;
    operand_d = OAMD_BYTE_RST;
    unique case (mode_q)
      OAMD_IMM:
      begin
        ea_d = pc_q; // Where the value byte lives.
        operand_d = inst_q[0]; // RULE_02
      end
      OAMD_SDIR, OAMD_BITDIR: ea_d = {OAMD_ZERO_PAGE, inst_q[0]}; // RULE_03
      OAMD_BTJDIR:
      begin
        ea_d = {OAMD_ZERO_PAGE, inst_q[0]};
        operand_d = inst_q[1];
      end
      OAMD_LDIR: ea_d = {inst_q[0], inst_q[1]}; // RULE_04
      OAMD_IX0: ea_d = {OAMD_ZERO_PAGE, idx_q}; // RULE_06
      OAMD_IX1: ea_d = {7'h00, {1'b0, idx_q} + {1'b0, inst_q[0]}}; // RULE_05 RULE_07
      OAMD_IX2: ea_d = {inst_q[0], inst_q[1]} + {8'h00, idx_q}; // RULE_05 RULE_08
      OAMD_SIND, OAMD_BITIND: ea_d = {OAMD_ZERO_PAGE, ptr_q[0]}; // RULE_11
      OAMD_BTJIND:
      begin
        ea_d = {OAMD_ZERO_PAGE, ptr_q[0]};
        operand_d = inst_q[1];
      end
      OAMD_LIND: ea_d = {ptr_q[0], ptr_q[1]}; // RULE_11
      OAMD_SINDX: ea_d = {7'h00, {1'b0, idx_q} + {1'b0, ptr_q[0]}}; // RULE_05 RULE_11
      OAMD_LINDX: ea_d = {ptr_q[0], ptr_q[1]} + {8'h00, idx_q}; // RULE_05 RULE_11
      OAMD_REL:
      begin
        // Target is the next instruction plus the signed displacement.
        ea_d = pc_q + 16'h0001 + {{8{inst_q[0][7]}}, inst_q[0]};
        operand_d = inst_q[0];
      end
      OAMD_RELIND:
      begin
        ea_d = pc_q + 16'h0001 + {{8{ptr_q[0][7]}}, ptr_q[0]};
        operand_d = ptr_q[0];
      end
      default:
      begin
        ea_d = OAMD_WORD_RST;
        operand_d = OAMD_BYTE_RST;
      end
    endcase
  end

  // Result registers; a refused request returns zeros with the error flag.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ea_q <= OAMD_WORD_RST;
      operand_q <= OAMD_BYTE_RST;
      len_q <= OAMD_CNT_RST;
    end
    else if (i_ce)
    begin
      done_q <= 1'b0;
      if ((state_q == CTL_IDLE) && i_start)
      begin
        busy_q <= 1'b1;
      end
      else if (state_q == CTL_CALC)
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        ea_q <= err_q ? OAMD_WORD_RST : ea_d;
        operand_q <= err_q ? OAMD_BYTE_RST : operand_d;
        len_q <= err_q ? OAMD_CNT_RST : oamd_len(mode_q); // RULE_10
      end
    end
  end

  // Count of reads per request, for the checks below.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rd_cnt_q <= 3'h0;
    end
    else if (i_ce)
    begin
      if ((state_q == CTL_IDLE) && i_start)
      begin
        rd_cnt_q <= 3'h0;
      end
      else if (mem_rd_q)
      begin
        rd_cnt_q <= rd_cnt_q + 3'h1;
      end
    end
  end

  // Outputs straight from their flip-flops.
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_err = err_q;
  assign o_ea = ea_q;
  assign o_operand = operand_q;
  assign o_len = len_q;
  assign o_mem_rd = mem_rd_q;
  assign o_mem_addr = mem_addr_q;

  // Checks on the decoded results and on the memory reads.
  mode_range_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_01
    (done_q && (mode_q > OAMD_BTJIND)) |-> err_q)
    else $error("Unknown mode code was not refused.");
  imm_value_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_02
    (done_q && (mode_q == OAMD_IMM)) |-> ((operand_q == inst_q[0]) && (len_q == 2'h1)
      && (rd_cnt_q == 3'h1) && (ea_q == pc_q)))
    else $error("Immediate operand or length is wrong.");
  short_dir_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_03
    (done_q && (mode_q == OAMD_SDIR)) |-> ((ea_q == {8'h00, inst_q[0]}) && (rd_cnt_q == 3'h1)))
    else $error("Short direct address is wrong.");
  long_dir_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_04
    (done_q && (mode_q == OAMD_LDIR) && !err_q) |-> (ea_q == {inst_q[0], inst_q[1]}))
    else $error("Long direct address is wrong.");
  index_sum_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_05
    (done_q && (mode_q == OAMD_IX2) && !err_q) |-> (ea_q == ({inst_q[0], inst_q[1]} + {8'h00, idx_q})))
    else $error("Indexed sum is wrong.");
  no_offset_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_06
    ((state_q == CTL_IDLE) && i_ce && i_start && (i_mode == OAMD_IX0) && !i_rmw)
      |=> ((state_q == CTL_CALC) && (rd_cnt_q == 3'h0)))
    else $error("No-offset indexed mode read a byte.");
  short_idx_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_07
    (done_q && (mode_q == OAMD_IX1)) |-> ((ea_q <= OAMD_SHORT_IDX_MAX)
      && (ea_q == ({8'h00, idx_q} + {8'h00, inst_q[0]}))))
    else $error("Short indexed address is wrong.");
  long_idx_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_08
    (done_q && (mode_q == OAMD_IX2) && !err_q) |-> ((len_q == 2'h2) && (rd_cnt_q == 3'h2)))
    else $error("Long indexed did not read two bytes.");
  rmw_short_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_09
    (done_q && (mode_q <= OAMD_BTJIND)) |-> (err_q == (rmw_q && oamd_is_long(mode_q))))
    else $error("Read-modify-write form check is wrong.");
  long_cost_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_10
    (done_q && (mode_q == OAMD_LDIR) && !err_q) |-> ((rd_cnt_q == 3'h2) && (len_q == 2'h2)))
    else $error("Long direct did not cost two bytes.");
  indirect_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_11
    (done_q && (mode_q == OAMD_LINDX) && !err_q) |-> ((rd_cnt_q == 3'h3)
      && (ea_q == ({ptr_q[0], ptr_q[1]} + {8'h00, idx_q}))))
    else $error("Long indirect indexed address is wrong.");
  ptr_page_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_11
    (mem_rd_q && (state_q == CTL_PTR)) |-> (mem_addr_q[15:8] == 8'h00))
    else $error("Pointer read left page zero.");

endmodule

`default_nettype wire

// File: verification/oamd_mem_model.sv
// Behavioural byte-wide memory that answers the decoder's read strobes.
`timescale 1ns/1ns
`default_nettype none

module oamd_mem_model (
  input wire logic i_clk, // Core clock.
  input wire logic i_mem_rd, // Read strobe from the decoder.
  input wire logic [15:0] i_mem_addr, // Read address from the decoder.
  output logic [7:0] o_mem_data // Read data, valid in the cycle after the strobe.
);
  // Storage that the bench fills before each request.
  logic [7:0] mem [0:65535];

  // Data appears after the edge that sees the strobe and is inverted one edge later.
  // The inversion makes a late capture show up as wrong data rather than a lucky match.
  always @(posedge i_clk)
  begin
    if (i_mem_rd)
    begin
      o_mem_data <= mem[i_mem_addr];
    end
    else
    begin
      o_mem_data <= ~o_mem_data;
    end
  end
endmodule

`default_nettype wire

// File: verification/oamd_decoder_tb.sv
// Self-checking bench for the operand address decoder with its memory model.
`timescale 1ns/1ns
`default_nettype none

module oamd_decoder_tb
  import oamd_pkg::*;
;
  logic clk, rst_n, ce, start, rmw, busy, done, err, mem_rd; // Control and status lines.
  logic [4:0] mode; // Requested mode code.
  logic [7:0] index, mem_data, operand; // Byte-wide values.
  logic [15:0] pc, ea, mem_addr; // Address values.
  logic [1:0] len; // Reported instruction length.
  int mismatches = 0; // Count of failed comparisons.
  int checks = 0; // Count of comparisons made.
  int cycles = 0; // Clock cycles since time zero.
  int reads = 0; // Read strobes seen.

  oamd_decoder u_oamd_decoder (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_start(start),
    .i_mode(mode), .i_rmw(rmw), .i_index(index), .i_pc(pc), .i_mem_data(mem_data),
    .o_busy(busy), .o_done(done), .o_err(err), .o_ea(ea), .o_operand(operand), .o_len(len),
    .o_mem_rd(mem_rd), .o_mem_addr(mem_addr));

  oamd_mem_model u_oamd_mem_model (.i_clk(clk), .i_mem_rd(mem_rd), .i_mem_addr(mem_addr),
    .o_mem_data(mem_data));

  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts cycles and strobes, and cuts a hang short at the ceiling.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (mem_rd === 1'b1)
    begin
      reads <= reads + 1;
    end
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and reports a difference at once.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Places one byte in the memory model.
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    u_oamd_mem_model.mem[a] = d;
  endtask

  // Issues one request and judges timing, read count and every result.
  task automatic run(input logic [4:0] m, input logic r, input logic [7:0] ix,
    input logic [15:0] p, input logic [15:0] x_ea, input logic [7:0] x_op,
    input logic [1:0] x_len, input logic x_err, input int x_cyc);
    int n;
    int r0;
    @(posedge clk);
    start <= 1'b1;
    mode <= m;
    rmw <= r;
    index <= ix;
    pc <= p;
    @(posedge clk);
    start <= 1'b0;
    r0 = reads;
    n = 0;
    #1;
    check("busy", 16'(busy), 16'h0001);
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    // The result follows the taking edge by one cycle plus three for every byte read.
    check("cycles", 16'(n), 16'(x_cyc));
    check("reads", 16'(reads - r0), 16'((x_cyc - 1) / 3));
    check("idle", 16'(busy), 16'h0000);
    check("err", 16'(err), 16'(x_err));
    check("ea", ea, x_ea);
    check("operand", 16'(operand), 16'(x_op));
    check("len", 16'(len), 16'(x_len));
    @(posedge clk);
    #1;
    check("pulse", 16'(done), 16'h0000);
  endtask

  // Immediate value is the byte after the opcode.
  task automatic s_immediate();
    put(16'h1234, 8'ha5);
    run(OAMD_IMM, 1'b0, 8'h00, 16'h1234, 16'h1234, 8'ha5, 2'h1, 1'b0, 4);
  endtask

  // Short and long direct, and a short form accepted for read-modify-write.
  task automatic s_direct();
    put(16'h2000, 8'hff);
    put(16'h3000, 8'h12);
    put(16'h3001, 8'h34);
    run(OAMD_SDIR, 1'b0, 8'h00, 16'h2000, 16'h00ff, 8'h00, 2'h1, 1'b0, 4);
    run(OAMD_LDIR, 1'b0, 8'h00, 16'h3000, 16'h1234, 8'h00, 2'h2, 1'b0, 7);
    run(OAMD_SDIR, 1'b1, 8'h00, 16'h2000, 16'h00ff, 8'h00, 2'h1, 1'b0, 4);
  endtask

  // Inherent and the three indexed forms at their boundary values.
  task automatic s_indexed();
    put(16'h2100, 8'hff);
    put(16'h2200, 8'hff);
    put(16'h2201, 8'hf0);
    run(OAMD_INH, 1'b0, 8'h00, 16'h2100, 16'h0000, 8'h00, 2'h0, 1'b0, 1);
    run(OAMD_IX0, 1'b0, 8'hff, 16'h2100, 16'h00ff, 8'h00, 2'h0, 1'b0, 1);
    run(OAMD_IX1, 1'b0, 8'hff, 16'h2100, 16'h01fe, 8'h00, 2'h1, 1'b0, 4);
    run(OAMD_IX2, 1'b0, 8'h20, 16'h2200, 16'h0010, 8'h00, 2'h2, 1'b0, 7);
  endtask

  // Indirect forms, including a word pointer that wraps within page zero.
  task automatic s_indirect();
    put(16'h4000, 8'h40);
    put(16'h0040, 8'h77);
    put(16'h4100, 8'hff);
    put(16'h00ff, 8'h9a);
    put(16'h0000, 8'hbc);
    put(16'h4200, 8'h50);
    put(16'h0050, 8'hf0);
    put(16'h4300, 8'h60);
    put(16'h0060, 8'hff);
    put(16'h0061, 8'hf0);
    run(OAMD_SIND, 1'b0, 8'h00, 16'h4000, 16'h0077, 8'h00, 2'h2, 1'b0, 7);
    run(OAMD_LIND, 1'b0, 8'h00, 16'h4100, 16'h9abc, 8'h00, 2'h2, 1'b0, 10);
    run(OAMD_SINDX, 1'b0, 8'h20, 16'h4200, 16'h0110, 8'h00, 2'h2, 1'b0, 7);
    run(OAMD_LINDX, 1'b0, 8'h20, 16'h4300, 16'h0010, 8'h00, 2'h2, 1'b0, 10);
  endtask

  // Relative and bit operation families.
  task automatic s_relative();
    put(16'h5000, 8'hfe);
    put(16'h5100, 8'h70);
    put(16'h0070, 8'h10);
    put(16'h5200, 8'h80);
    put(16'h5300, 8'h90);
    put(16'h0090, 8'ha0);
    put(16'h5400, 8'hb0);
    put(16'h5401, 8'h05);
    put(16'h5500, 8'hc0);
    put(16'h5501, 8'hfb);
    put(16'h00c0, 8'hd0);
    run(OAMD_REL, 1'b0, 8'h00, 16'h5000, 16'h4fff, 8'hfe, 2'h1, 1'b0, 4);
    run(OAMD_RELIND, 1'b0, 8'h00, 16'h5100, 16'h5111, 8'h10, 2'h2, 1'b0, 7);
    run(OAMD_BITDIR, 1'b0, 8'h00, 16'h5200, 16'h0080, 8'h00, 2'h1, 1'b0, 4);
    run(OAMD_BITIND, 1'b0, 8'h00, 16'h5300, 16'h00a0, 8'h00, 2'h2, 1'b0, 7);
    run(OAMD_BTJDIR, 1'b0, 8'h00, 16'h5400, 16'h00b0, 8'h05, 2'h2, 1'b0, 7);
    run(OAMD_BTJIND, 1'b0, 8'h00, 16'h5500, 16'h00d0, 8'hfb, 2'h3, 1'b0, 10);
  endtask

  // Long forms under read-modify-write and codes past the last mode are refused.
  task automatic s_refused();
    logic [4:0] codes [6] = '{5'h03, 5'h06, 5'h08, 5'h0a, 5'h11, 5'h1f};
    foreach (codes[i])
    begin
      run(codes[i], i < 4, 8'h00, 16'h6000, 16'h0000, 8'h00, 2'h0, 1'b1, 1);
    end
  endtask

  // A request held while the clock enable is low must not be taken.
  task automatic s_enable();
    @(posedge clk);
    ce <= 1'b0;
    start <= 1'b1;
    mode <= OAMD_IX0;
    index <= 8'h3c;
    repeat (3) @(posedge clk);
    #1;
    check("hold", 16'(busy), 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    start <= 1'b0;
    run(OAMD_IX0, 1'b0, 8'h3c, 16'h0000, 16'h003c, 8'h00, 2'h0, 1'b0, 1);
  endtask

  // Main sequence: reset for five cycles, then every scenario.
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    start = 1'b0;
    mode = 5'h00;
    rmw = 1'b0;
    index = 8'h00;
    pc = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    s_immediate();
    s_direct();
    s_indexed();
    s_indirect();
    s_relative();
    s_refused();
    s_enable();
    test_done();
  end
endmodule

`default_nettype wire
